// ===== design/sram_ctrl_end.sv
// controller end of the burst sram link, with its write data fifo
`timescale 1ns/1ps
`include "sram_link_consts.svh"
module sram_ctrl_fifo #(
  parameter int W = 20,
  parameter int DEPTH = 16
) (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [W-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [W-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic ready_r;
  logic valid_r;
  logic push;
  logic pop;
  logic [AW:0] count_nxt;
  assign push = i_in_valid & ready_r;
  assign pop = i_out_ready & valid_r;
  assign count_nxt = count_r + (AW+1)'(push) - (AW+1)'(pop);
  assign o_in_ready = ready_r;
  assign o_out_valid = valid_r;
  assign o_out_data = mem[rd_ptr_r];

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
      ready_r <= 1'b0;
      valid_r <= 1'b0;
    end else begin
      wr_ptr_r <= wr_ptr_r + AW'(push);
      rd_ptr_r <= rd_ptr_r + AW'(pop);
      count_r <= count_nxt;
      ready_r <= count_nxt != (AW+1)'(DEPTH);
      valid_r <= count_nxt != '0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (push) begin
      mem[wr_ptr_r] <= i_in_data;
    end
  end
endmodule : sram_ctrl_fifo

module sram_ctrl_end (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  sram_link_if.ctl link,
  input wire logic i_single_clock,
  input wire logic i_clock_stop,
  input wire logic i_cmd_valid,
  output logic o_cmd_ready,
  input wire logic i_cmd_write,
  input wire logic [`ADDR_W-1:0] i_cmd_addr,
  input wire logic i_wdata_valid,
  output logic o_wdata_ready,
  input wire logic [`DATA_W-1:0] i_wdata,
  input wire logic [`WSEL_W-1:0] i_wsel_n,
  output logic o_rdata_valid,
  output logic [`DATA_W-1:0] o_rdata
);
  logic k_r;
  logic kn_r;
  logic c_r;
  logic cn_r;
  logic rps_n_r;
  logic wps_n_r;
  logic [`ADDR_W-1:0] addr_r;
  logic [`DATA_W-1:0] d_r;
  logic [`WSEL_W-1:0] bws_n_r;
  logic cmd_full_r;
  logic cmd_ready_r;
  logic cmd_write_r;
  logic [`ADDR_W-1:0] cmd_addr_r;
  sram_pkg::op_t last_r;
  logic wr_arm_r;
  logic wr_busy_r;
  logic [`BEAT_W-1:0] wr_beat_r;
  logic tog_r;
  logic tog_d_r;
  logic rvalid_r;
  logic [`DATA_W-1:0] rdata_r;

  logic f_valid;
  logic [`DATA_W+`WSEL_W-1:0] f_data;

  // a stop parks both clocks high; leaving the park never makes a rise
  logic k_nxt;
  logic kn_nxt;
  logic pos_nxt;
  logic neg_nxt;
  assign k_nxt = i_clock_stop | ~k_r; // RULE_04
  assign kn_nxt = i_clock_stop | ~k_nxt; // RULE_04
  assign pos_nxt = k_nxt & ~k_r & ~kn_nxt;
  assign neg_nxt = kn_nxt & ~kn_r & ~k_nxt;

  logic issue_ok;
  logic issue;
  logic take;
  logic cmd_full_nxt;
  logic beat_start;
  logic beat_cont;
  logic beat;
  logic pop;
  assign issue_ok = cmd_full_r & (cmd_write_r ? last_r != sram_pkg::op_write
                                              : last_r != sram_pkg::op_read); // RULE_08
  assign issue = pos_nxt & issue_ok;
  assign take = i_cmd_valid & cmd_ready_r;
  assign cmd_full_nxt = issue ? 1'b0 : (take | cmd_full_r);
  assign beat_start = pos_nxt & wr_arm_r; // RULE_01
  assign beat_cont = (pos_nxt | neg_nxt) & wr_busy_r & ~beat_start;
  assign beat = beat_start | beat_cont;
  // a starved fifo sends a masked beat instead of stalling the burst
  assign pop = beat & f_valid;

  sram_ctrl_fifo #(
    .W(`DATA_W + `WSEL_W),
    .DEPTH(`FIFO_DEPTH)
  ) u_wfifo (
    .i_core_clk(i_core_clk),
    .i_reset_n(i_reset_n),
    .i_in_valid(i_wdata_valid),
    .o_in_ready(o_wdata_ready),
    .i_in_data({i_wsel_n, i_wdata}),
    .o_out_valid(f_valid),
    .i_out_ready(pop),
    .o_out_data(f_data)
  );

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      k_r <= `PARK;
      kn_r <= `PARK;
      c_r <= `PARK;
      cn_r <= `PARK;
      tog_r <= 1'b0;
      tog_d_r <= 1'b0;
    end else begin
      k_r <= k_nxt;
      kn_r <= kn_nxt;
      c_r <= i_single_clock | k_nxt; // RULE_15
      cn_r <= i_single_clock | kn_nxt; // RULE_15
      tog_r <= pos_nxt | neg_nxt;
      tog_d_r <= tog_r;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cmd_full_r <= 1'b0;
      cmd_ready_r <= 1'b0;
      cmd_write_r <= 1'b0;
      cmd_addr_r <= '0;
    end else begin
      cmd_full_r <= cmd_full_nxt;
      cmd_ready_r <= ~cmd_full_nxt;
      if (take) begin
        cmd_write_r <= i_cmd_write;
        cmd_addr_r <= i_cmd_addr;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rps_n_r <= `PARK;
      wps_n_r <= `PARK;
      addr_r <= '0;
      last_r <= sram_pkg::op_none;
      wr_arm_r <= 1'b0;
    end else if (pos_nxt) begin
      rps_n_r <= ~(issue & ~cmd_write_r);
      wps_n_r <= ~(issue & cmd_write_r); // RULE_01
      wr_arm_r <= issue & cmd_write_r;
      if (issue) begin
        addr_r <= cmd_addr_r;
        last_r <= cmd_write_r ? sram_pkg::op_write : sram_pkg::op_read;
      end else begin
        last_r <= sram_pkg::op_none;
      end
    end
  end

  // beats 0..3 on k rise t+1, k_n rise t+1, k rise t+2, k_n rise t+2
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wr_busy_r <= 1'b0;
      wr_beat_r <= `FIRST_BEAT;
      d_r <= '0;
      bws_n_r <= `SEL_NONE;
    end else begin
      if (pos_nxt || neg_nxt) begin
        bws_n_r <= pop ? f_data[`DATA_W +: `WSEL_W] : `SEL_NONE; // RULE_14
      end
      if (pop) begin
        d_r <= f_data[`DATA_W-1:0];
      end
      if (beat_start) begin
        wr_busy_r <= 1'b1;
        wr_beat_r <= `SECOND_BEAT;
      end else if (beat_cont) begin
        wr_beat_r <= wr_beat_r + `SECOND_BEAT;
        if (wr_beat_r == `LAST_BEAT) begin
          wr_busy_r <= 1'b0;
        end
      end
    end
  end

  // the device answers one edge after it sees ours, so sample one later
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
    end else begin
      rvalid_r <= tog_d_r & ~link.q_oe_n; // RULE_02
      rdata_r <= link.q;
    end
  end

  assign link.k = k_r;
  assign link.k_n = kn_r;
  assign link.c = c_r;
  assign link.c_n = cn_r;
  assign link.read_port_select_n = rps_n_r;
  assign link.write_port_select_n = wps_n_r;
  assign link.addr = addr_r;
  assign link.d = d_r;
  assign link.byte_write_select_n = bws_n_r;
  assign o_cmd_ready = cmd_ready_r;
  assign o_rdata_valid = rvalid_r;
  assign o_rdata = rdata_r;
endmodule : sram_ctrl_end

// ===== design/sram_link_consts.svh
// named constants shared by both ends of the burst sram link
`ifndef SRAM_LINK_CONSTS_SVH
`define SRAM_LINK_CONSTS_SVH
`define DATA_W 18
`define ADDR_W 10
`define WSEL_W 2
`define BEAT_W 2
`define NIB_W 4
`define BYTE_W 9
`define MEM_DEPTH 1024
`define FIFO_DEPTH 16
`define FIRST_BEAT 2'h0
`define SECOND_BEAT 2'h1
`define LAST_BEAT 2'h3
`define SEL_NONE 2'h3
`define PARK 1'b1
`define ACTIVE_N 1'b0
`endif

// ===== design/sram_pkg.sv
// types and helper functions of the burst sram link
`include "sram_link_consts.svh"
package sram_pkg;
  typedef enum logic [1:0] {org_x8, org_x9, org_x18} org_t;
  typedef enum logic [1:0] {op_none, op_read, op_write} op_t;

  function automatic logic [`ADDR_W-1:0] burst_addr(
    input logic [`ADDR_W-1:0] base,
    input logic [`BEAT_W-1:0] beat);
    return base + `ADDR_W'(beat);
  endfunction : burst_addr

  function automatic logic [`DATA_W-1:0] write_mask(
    input org_t org,
    input logic [`WSEL_W-1:0] sel_n);
    logic [`DATA_W-1:0] m;
    m = '0;
    unique case (org)
      org_x8: m = `DATA_W'({{`NIB_W{~sel_n[1]}}, {`NIB_W{~sel_n[0]}}});
      org_x9: m = `DATA_W'({`BYTE_W{~sel_n[0]}});
      org_x18: m = {{`BYTE_W{~sel_n[1]}}, {`BYTE_W{~sel_n[0]}}};
      default: m = '0;
    endcase
    return m;
  endfunction : write_mask
endpackage : sram_pkg

// ===== design/sram_link_if.sv
// pin bundle between the memory controller and the burst sram
`timescale 1ns/1ps
`include "sram_link_consts.svh"
interface sram_link_if;
  logic k;
  logic k_n;
  logic c;
  logic c_n;
  logic read_port_select_n;
  logic write_port_select_n;
  logic [`ADDR_W-1:0] addr;
  logic [`DATA_W-1:0] d;
  logic [`WSEL_W-1:0] byte_write_select_n;
  logic [`DATA_W-1:0] q;
  logic q_oe_n;

  modport dev (
    input k, k_n, c, c_n, read_port_select_n, write_port_select_n,
    input addr, d, byte_write_select_n,
    output q, q_oe_n
  );
  modport ctl (
    output k, k_n, c, c_n, read_port_select_n, write_port_select_n,
    output addr, d, byte_write_select_n,
    input q, q_oe_n
  );
endinterface : sram_link_if

// ===== design/sram_device_end.sv
// device end: four word burst sram with separate read and write ports
`timescale 1ns/1ps
`include "sram_link_consts.svh"
// Notes on behaviour
// [RULE_01] write selected low starts burst, data follows
// [RULE_02] read words leave on alternating output edges
// [RULE_03] both selects high: nothing starts, outputs off
// [RULE_04] stopped clocks hold every state
// [RULE_05] reset leaves ports idle, outputs tristated
// [RULE_06] burst covers base address then three more
// [RULE_07] select ignored right after it started op
// [RULE_08] same type back to back: second dropped
// [RULE_09] write on input edges, read on output edges
// [RULE_10] x8: each nibble select masks one nibble
// [RULE_11] x18: each byte select masks nine bits
// [RULE_12] x9: single select masks all nine bits
// [RULE_13] all selects high writes nothing that beat
// [RULE_14] selects sampled fresh with each data word
// [RULE_15] output clocks high at start: single clock
// [RULE_16] both selected: priority by previous operation
module sram_device_end #(
  parameter sram_pkg::org_t ORG = sram_pkg::org_x18
) (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  sram_link_if.dev link,
  output logic o_single_clock,
  output logic o_read_busy,
  output logic o_write_busy
);
  logic [`DATA_W-1:0] mem [`MEM_DEPTH];

  logic k_r;
  logic kn_r;
  logic c_r;
  logic cn_r;
  logic strap_done_r;
  logic single_r;
  sram_pkg::op_t last_r;

  logic rd_arm_r;
  logic [`ADDR_W-1:0] rd_arm_addr_r;
  logic pend_r;
  logic [`ADDR_W-1:0] pend_addr_r;
  logic out_busy_r;
  logic [`BEAT_W-1:0] out_beat_r;
  logic [`ADDR_W-1:0] out_addr_r;
  logic [`DATA_W-1:0] q_r;
  logic q_oe_n_r;

  logic wr_arm_r;
  logic [`ADDR_W-1:0] wr_arm_addr_r;
  logic wr_busy_r;
  logic [`BEAT_W-1:0] wr_beat_r;
  logic [`ADDR_W-1:0] wr_base_r;

  // an edge counts only while its pair is complementary, so parking both
  // clocks high and leaving that park never fakes a rise
  logic k_pos;
  logic kn_pos;
  logic c_pos;
  logic cn_pos;
  assign k_pos = link.k & ~k_r & ~link.k_n;
  assign kn_pos = link.k_n & ~kn_r & ~link.k;
  assign c_pos = link.c & ~c_r & ~link.c_n;
  assign cn_pos = link.c_n & ~cn_r & ~link.c;

  logic o_pos;
  logic o_neg;
  logic o_edge;
  assign o_pos = single_r ? k_pos : c_pos; // RULE_09
  assign o_neg = single_r ? kn_pos : cn_pos; // RULE_09
  assign o_edge = o_pos | o_neg;

  // arbitration of the two selects on a positive input edge
  logic rd_req;
  logic wr_req;
  logic start_rd;
  logic start_wr;
  assign rd_req = ~link.read_port_select_n & (last_r != sram_pkg::op_read); // RULE_07
  assign wr_req = ~link.write_port_select_n & (last_r != sram_pkg::op_write); // RULE_08
  assign start_rd = k_pos & rd_req; // RULE_16
  assign start_wr = k_pos & wr_req & ~rd_req; // RULE_16

  logic emit_cont;
  logic emit_start;
  logic [`ADDR_W-1:0] emit_addr;
  assign emit_cont = o_edge & out_busy_r;
  assign emit_start = o_neg & ~out_busy_r & pend_r; // RULE_02
  assign emit_addr = emit_cont ? sram_pkg::burst_addr(out_addr_r, out_beat_r)
                               : pend_addr_r; // RULE_06

  logic wr_start;
  logic wr_cont;
  logic wr_now;
  logic [`ADDR_W-1:0] wr_idx;
  logic [`DATA_W-1:0] wr_mask;
  assign wr_start = k_pos & wr_arm_r; // RULE_01
  assign wr_cont = (k_pos | kn_pos) & wr_busy_r & ~wr_start; // RULE_09
  assign wr_now = wr_start | wr_cont;
  assign wr_idx = wr_start ? wr_arm_addr_r
                           : sram_pkg::burst_addr(wr_base_r, wr_beat_r); // RULE_06
  // each beat takes the selects that travel with it
  assign wr_mask = sram_pkg::write_mask(ORG, link.byte_write_select_n); // RULE_14

  // pair-edge history and the clock mode strap
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      k_r <= `PARK;
      kn_r <= `PARK;
      c_r <= `PARK;
      cn_r <= `PARK;
      strap_done_r <= 1'b0;
      single_r <= 1'b0;
    end else begin
      k_r <= link.k;
      kn_r <= link.k_n;
      c_r <= link.c;
      cn_r <= link.c_n;
      // taken on the first input rise; no output edge is needed earlier
      if (k_pos && !strap_done_r) begin
        strap_done_r <= 1'b1;
        single_r <= link.c & link.c_n; // RULE_15
      end
    end
  end

  // what was started on the last positive input edge
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      last_r <= sram_pkg::op_none; // RULE_05
    end else if (k_pos) begin
      if (start_rd) begin
        last_r <= sram_pkg::op_read;
      end else if (start_wr) begin
        last_r <= sram_pkg::op_write;
      end else begin
        last_r <= sram_pkg::op_none; // RULE_03
      end
    end
  end

  // read address stages: taken at t, handed to the output side at t+1
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rd_arm_r <= 1'b0;
      rd_arm_addr_r <= '0;
      pend_r <= 1'b0;
      pend_addr_r <= '0;
    end else begin
      if (k_pos) begin
        rd_arm_r <= start_rd; // RULE_02
      end
      if (start_rd) begin
        rd_arm_addr_r <= link.addr; // RULE_06
      end
      if (emit_start) begin
        pend_r <= 1'b0;
      end else if (k_pos && rd_arm_r) begin
        pend_r <= 1'b1;
        pend_addr_r <= rd_arm_addr_r;
      end
    end
  end

  // output burst: one word per output edge, tristate on an idle edge
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      out_busy_r <= 1'b0;
      out_beat_r <= `FIRST_BEAT;
      out_addr_r <= '0;
      q_r <= '0;
      q_oe_n_r <= `PARK; // RULE_05
    end else begin
      if (emit_start || emit_cont) begin
        q_r <= mem[emit_addr]; // RULE_02
        q_oe_n_r <= `ACTIVE_N;
      end else if (o_edge) begin
        q_oe_n_r <= `PARK; // RULE_03
      end
      if (emit_start) begin
        out_busy_r <= 1'b1;
        out_beat_r <= `SECOND_BEAT;
        out_addr_r <= pend_addr_r;
      end else if (emit_cont) begin
        out_beat_r <= out_beat_r + `SECOND_BEAT;
        if (out_beat_r == `LAST_BEAT) begin
          out_busy_r <= 1'b0;
        end
      end
    end
  end

  // write burst: beat 0 on the rise after the command, then every edge
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wr_arm_r <= 1'b0;
      wr_arm_addr_r <= '0;
      wr_busy_r <= 1'b0;
      wr_beat_r <= `FIRST_BEAT;
      wr_base_r <= '0;
    end else begin
      if (k_pos) begin
        wr_arm_r <= start_wr; // RULE_01
      end
      if (start_wr) begin
        wr_arm_addr_r <= link.addr;
      end
      if (wr_start) begin
        wr_busy_r <= 1'b1;
        wr_beat_r <= `SECOND_BEAT;
        wr_base_r <= wr_arm_addr_r;
      end else if (wr_cont) begin
        wr_beat_r <= wr_beat_r + `SECOND_BEAT;
        if (wr_beat_r == `LAST_BEAT) begin
          wr_busy_r <= 1'b0;
        end
      end
    end
  end

  // array holds no reset: contents are undefined until written
  always_ff @(posedge i_core_clk) begin
    if (wr_now) begin
      // RULE_10 RULE_11 RULE_12 RULE_13
      mem[wr_idx] <= (mem[wr_idx] & ~wr_mask) | (link.d & wr_mask);
    end
  end

  // with no edges nothing above advances, so a stopped clock holds all
  assign link.q = q_r; // RULE_04
  assign link.q_oe_n = q_oe_n_r;
  assign o_single_clock = single_r;
  assign o_read_busy = out_busy_r;
  assign o_write_busy = wr_busy_r;
endmodule : sram_device_end

// ===== testbench/sram_link_asserts.sv
// concurrent checks on the pins between the two ends of the burst sram link
`timescale 1ns/1ps
`include "sram_link_consts.svh"
module sram_link_asserts (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic k,
  input wire logic k_n,
  input wire logic c,
  input wire logic c_n,
  input wire logic read_port_select_n,
  input wire logic write_port_select_n,
  input wire logic [`ADDR_W-1:0] addr,
  input wire logic [`DATA_W-1:0] d,
  input wire logic [`WSEL_W-1:0] byte_write_select_n,
  input wire logic [`DATA_W-1:0] q,
  input wire logic q_oe_n
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_reset_n);

  sequence s_read_start;
    k && !k_n && !read_port_select_n && q_oe_n;
  endsequence
  sequence s_four_words;
    !q_oe_n [*4];
  endsequence
  sequence s_parked;
    k && k_n && c && c_n;
  endsequence

  property p_reset_idle;
    $rose(i_reset_n) |-> q_oe_n && read_port_select_n && write_port_select_n;
  endproperty
  // a select stands a whole input period, so look from the sample where k has just risen
  property p_wps_gap;
    k && !k_n && !write_port_select_n |-> ##2 write_port_select_n [*2];
  endproperty
  property p_rps_gap;
    k && !k_n && !read_port_select_n |-> ##2 read_port_select_n [*2];
  endproperty
  property p_one_op;
    !(!read_port_select_n && !write_port_select_n);
  endproperty
  property p_clk_pair;
    (k != k_n) || (k && k_n);
  endproperty
  property p_out_clk;
    (c && c_n) || (c == k && c_n == k_n);
  endproperty
  property p_q_hold;
    s_parked ##1 s_parked |-> $stable(q) && $stable(q_oe_n);
  endproperty
  property p_read_lat;
    s_read_start |-> ##[2:5] !q_oe_n;
  endproperty
  property p_oe_len;
    $fell(q_oe_n) |-> s_four_words;
  endproperty

  a_reset_idle: assert property (p_reset_idle) else $error("link busy after reset");
  a_wps_gap: assert property (p_wps_gap) else $error("write select misplaced");
  a_rps_gap: assert property (p_rps_gap) else $error("read select misplaced");
  a_one_op: assert property (p_one_op) else $error("both selects low");
  a_clk_pair: assert property (p_clk_pair) else $error("input clock pair broken");
  a_out_clk: assert property (p_out_clk) else $error("output clock off input");
  a_q_hold: assert property (p_q_hold) else $error("q moved with clocks parked");
  a_read_lat: assert property (p_read_lat) else $error("read data late");
  a_oe_len: assert property (p_oe_len) else $error("read burst short");
endmodule : sram_link_asserts

// ===== testbench/tb_top.sv
// self-checking bench joining controller end and device end of the sram link
`timescale 1ns/1ps
`include "sram_link_consts.svh"
module tb_top;
  logic core_clk;
  logic reset_n;
  logic clock_stop;
  logic cmd_valid, cmd_ready, cmd_write, wdata_valid, wdata_ready, rdata_valid;
  logic single_clk, rd_busy, wr_busy;
  logic strap_single;
  logic [`ADDR_W-1:0] cmd_addr;
  logic [`DATA_W-1:0] wdata, rdata, qs;
  logic [`WSEL_W-1:0] wsel_n;
  logic [`DATA_W-1:0] mem [`MEM_DEPTH];
  logic [19:0] wq [$];
  int n_compared = 0;
  int miscompares = 0;
  int cycles = 0;

  sram_link_if link();
  sram_device_end #(.ORG(sram_pkg::org_x18)) u_sram_device_end (.i_core_clk(core_clk),
    .i_reset_n(reset_n), .link(link), .o_single_clock(single_clk), .o_read_busy(rd_busy),
    .o_write_busy(wr_busy));
  sram_ctrl_end u_sram_ctrl_end (.i_core_clk(core_clk), .i_reset_n(reset_n), .link(link),
    .i_single_clock(strap_single), .i_clock_stop(clock_stop), .i_cmd_valid(cmd_valid),
    .o_cmd_ready(cmd_ready), .i_cmd_write(cmd_write), .i_cmd_addr(cmd_addr),
    .i_wdata_valid(wdata_valid), .o_wdata_ready(wdata_ready), .i_wdata(wdata),
    .i_wsel_n(wsel_n), .o_rdata_valid(rdata_valid), .o_rdata(rdata));
  sram_link_asserts u_sram_link_asserts (.i_core_clk(core_clk), .i_reset_n(reset_n),
    .k(link.k), .k_n(link.k_n), .c(link.c), .c_n(link.c_n),
    .read_port_select_n(link.read_port_select_n),
    .write_port_select_n(link.write_port_select_n), .addr(link.addr), .d(link.d),
    .byte_write_select_n(link.byte_write_select_n), .q(link.q), .q_oe_n(link.q_oe_n));

  initial begin
    core_clk = 1'h0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic close_out();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out

  // generous ceiling: the whole sequence needs well under a thousand cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      close_out();
    end
  end

  task automatic step();
    @(posedge core_clk);
    #1;
  endtask : step

  // bounded wait; ready and valid flags are registered, so a level seen now is taken next edge
  task automatic wait_for(ref logic s);
    for (int n = 0; n < 60 && s !== 1'h1; n++) step();
    if (s !== 1'h1) begin
      miscompares++;
      $display("[ERR] handshake wait expected 1 seen %b", s);
    end
  endtask : wait_for

  task automatic cmp_bit(input string nm, input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %b seen %b", nm, e, g);
    end
  endtask : cmp_bit

  task automatic cmp_word(input string nm, input logic [`DATA_W-1:0] e,
    input logic [`DATA_W-1:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp_word

  task automatic push(input logic [`DATA_W-1:0] dv, input logic [`WSEL_W-1:0] s);
    wdata = dv;
    wsel_n = s;
    wdata_valid = 1'h1;
    wait_for(wdata_ready);
    step();
    wq.push_back({s, dv});
  endtask : push

  // the model takes the queued words as beats 0..3; an empty queue means a beat with no write
  task automatic cmd(input logic w, input logic [`ADDR_W-1:0] a);
    logic [19:0] e;
    logic [`DATA_W-1:0] m;
    logic [`ADDR_W-1:0] ia;
    step();
    cmd_write = w;
    cmd_addr = a;
    cmd_valid = 1'h1;
    wait_for(cmd_ready);
    step();
    cmd_valid = 1'h0;
    for (int b = 0; b < 4 && w; b++) begin
      if (wq.size() > 0) begin
        e = wq.pop_front();
        m = {{`BYTE_W{~e[19]}}, {`BYTE_W{~e[18]}}};
        ia = a + `ADDR_W'(b);
        mem[ia] = (mem[ia] & ~m) | (e[17:0] & m);
      end
    end
  endtask : cmd

  task automatic collect(input logic [`ADDR_W-1:0] a);
    logic [`ADDR_W-1:0] ia;
    for (int b = 0; b < 4; b++) begin
      wait_for(rdata_valid);
      ia = a + `ADDR_W'(b);
      cmp_word("rdata", mem[ia], rdata);
      step();
    end
  endtask : collect

  task automatic t_reset();
    repeat (3) @(posedge core_clk);
    #1;
    cmp_bit("q_oe_n", 1'h1, link.q_oe_n);
    cmp_bit("read select", 1'h1, link.read_port_select_n);
    cmp_bit("write select", 1'h1, link.write_port_select_n);
    reset_n = 1'h1;
    step();
    step();
  endtask : t_reset

  // fills the fifo, then writes: full bursts first, masked overwrites second
  task automatic t_fill_write();
    for (int i = 0; i < 16; i++) begin
      push(`DATA_W'(i * 18'h0_4c2d + 18'h0_0137), (i < 8) ? 2'h0 : `WSEL_W'(i * 3));
    end
    wdata_valid = 1'h0;
    step();
    cmp_bit("fifo ready", 1'h0, wdata_ready);
    cmd(1'h1, 10'h3fe);
    cmd(1'h1, 10'h010);
    cmd(1'h1, 10'h3fe);
    cmd(1'h1, 10'h010);
    repeat (12) step();
  endtask : t_fill_write

  task automatic t_read_pair();
    fork
      begin
        cmd(1'h0, 10'h3fe);
        cmd(1'h0, 10'h010);
      end
      begin
        collect(10'h3fe);
        collect(10'h010);
      end
    join
  endtask : t_read_pair

  task automatic t_empty_write();
    cmd(1'h1, 10'h010);
    // the burst runs four to six or five to seven edges after the command is taken, by k phase
    repeat (5) step();
    cmp_bit("write busy", 1'h1, wr_busy);
    cmd(1'h0, 10'h010);
    collect(10'h010);
  endtask : t_empty_write

  // clocks parked in mid read burst; the burst resumes when they run again
  task automatic t_stop();
    fork
      cmd(1'h0, 10'h3fe);
      collect(10'h3fe);
      begin
        wait_for(rdata_valid);
        clock_stop = 1'h1;
        repeat (4) step();
        cmp_bit("k parked", 1'h1, link.k);
        cmp_bit("k_n parked", 1'h1, link.k_n);
        cmp_bit("read busy", 1'h1, rd_busy);
        qs = link.q;
        step();
        cmp_word("q held", qs, link.q);
        clock_stop = 1'h0;
      end
    join
  endtask : t_stop

  // the x8 and x9 organisations are checked on the package mask decode alone; the bench device is x18
  task automatic t_masks();
    cmp_word("x8 mask", 18'h0_00f0, sram_pkg::write_mask(sram_pkg::org_x8, 2'h1));
    cmp_word("x8 mask", 18'h0_000f, sram_pkg::write_mask(sram_pkg::org_x8, 2'h2));
    cmp_word("x9 mask", 18'h0_01ff, sram_pkg::write_mask(sram_pkg::org_x9, 2'h2));
    cmp_word("x9 mask", 18'h0_0000, sram_pkg::write_mask(sram_pkg::org_x9, 2'h1));
  endtask : t_masks

  // second reset with the output clocks strapped high: reads then leave on input edges
  task automatic t_single();
    cmp_bit("single clock", 1'h0, single_clk);
    reset_n = 1'h0;
    strap_single = 1'h1;
    repeat (3) step();
    reset_n = 1'h1;
    step();
    step();
    fork
      cmd(1'h0, 10'h3fe);
      collect(10'h3fe);
    join
    cmp_bit("single clock", 1'h1, single_clk);
  endtask : t_single

  initial begin
    reset_n = 1'h0;
    clock_stop = 1'h0;
    strap_single = 1'h0;
    cmd_valid = 1'h0;
    cmd_write = 1'h0;
    cmd_addr = '0;
    wdata_valid = 1'h0;
    wdata = '0;
    wsel_n = 2'h3;
    t_reset();
    t_fill_write();
    t_read_pair();
    t_empty_write();
    t_stop();
    t_masks();
    t_single();
    repeat (10) step();
    close_out();
  end
endmodule : tb_top
